// >>> shared/decoder_defines.vh
// Constants for the control, literal and table instruction decoder.
`ifndef DECODER_DEFINES_VH
`define DECODER_DEFINES_VH
// ----------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_ACCUM 8'h08
`define OFS_IPTR 8'h0C
`define OFS_BANK 8'h10
`define OFS_STACK 8'h14
// ----------------------------------------------------------------
// Control fields and reset value.
// ----------------------------------------------------------------
`define CTL_RUN 0
`define CTL_PRESCALE 1
`define CTL_WRITE_EN 2
`define CONTROL_RESET 3'h0
// ----------------------------------------------------------------
// Status fields.
// ----------------------------------------------------------------
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_OV 3
`define ST_N 4
`define ST_TO 5
`define ST_PD 6
`define ST_GIEH 7
`define ST_GIEL 8
`define ST_WBUSY 9
`define ST_SP_LSB 16
// ----------------------------------------------------------------
// Opcode fields.
// ----------------------------------------------------------------
`define OP_SYSTEM 8'h00
`define OP_BANK 8'h01
`define OP_SUB 4'h8
`define OP_IOR 4'h9
`define OP_XOR 4'hA
`define OP_AND 4'hB
`define OP_RETLIT 4'hC
`define OP_MUL 4'hD
`define OP_MOV 4'hE
`define OP_ADD 4'hF
`define SYS_STANDBY 8'h03
`define SYS_KICK 8'h04
`define SYS_STORE_TOP 8'h05
`define SYS_REMOVE_TOP 8'h06
`define SYS_SOFT_RESET 8'hFF
`define NIB_ZERO 4'h0
`define NIB_CONDJ 4'hE
`define NIB_RELJ 4'hD
`define NIB_SECOND 4'hF
`define CONDJ_LAST 4'h7
`define LIT_POINTER 4'hE
`define LIT_ABS_JUMP 4'hF
`endif

// >>> rtl/control_literal_table_decoder.v
// Instruction decoder for control, literal and table operations with an AXI4-Lite register port.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Function
// RQ1 - Conditional jumps 1110 0000..0111 test Z,NZ,C,NC,OV,NOV,N,NN; 1 or 2 cycles.
// RQ2 - A taken relative jump loads pointer plus two plus twice the offset.
// RQ3 - Subroutine and absolute jumps are two words, twenty address bits, two cycles.
// RQ4 - A lone 1111 word and the all-zero word run as one-cycle idles.
// RQ5 - Pointer change or true test costs a second, idle cycle.
// RQ6 - Standby and watchdog kick update expiry and power-down flags; soft reset clears status.
// RQ7 - Stack-top store and remove take one cycle and touch no status.
// RQ8 - Interrupt return re-enables both interrupt enables; both returns take two cycles.
// RQ9 - Literal return loads the accumulator, returns, two cycles, status unchanged.
// RQ10 - Literal add, subtract, and, or, xor in one cycle with their flags.
// RQ11 - Literal move and multiply take one cycle and leave status alone.
// RQ12 - Bank literal load copies four bits into the bank register low nibble.
// RQ13 - Pointer literal load writes twelve bits into the chosen pointer, two cycles.
// RQ14 - Table fetch 10xx decodes four pointer modes, two cycles, no status.
// RQ15 - Table store 11xx decodes four pointer modes, two cycles, no status.
// RQ16 - A launched memory write runs until terminated, regardless of later words.
// RQ17 - Port read-modify-write sources take the pin levels, not the latch.
// RQ18 - A timer-zero count write clears the prescaler when it is assigned.
// RQ19 - Conditional tests use the flags left by the preceding instruction.
`include "decoder_defines.vh"
module control_literal_table_decoder #(
  parameter STACK_DEPTH = 31,
  parameter SP_WIDTH = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] instr_word,
  input wire instr_valid,
  output wire instr_ready,
  input wire [7:0] port_b_pins,
  input wire file_is_port,
  input wire [7:0] file_latch_value,
  output wire [7:0] file_source,
  input wire timer_zero_write,
  output reg prescaler_clear,
  input wire write_done,
  output reg table_fetch,
  output reg table_store,
  output reg [1:0] table_mode,
  output reg watchdog_kick,
  output reg standby,
  output reg soft_reset,
  output reg [15:0] product,
  output reg [20:0] instruction_pointer,
  output reg [7:0] working_accumulator,
  output wire [11:0] indirect_pointer_0,
  output wire [11:0] indirect_pointer_1,
  output wire [11:0] indirect_pointer_2
);
  reg [2:0] control;
  reg [4:0] flags;
  reg watchdog_expiry_flag, power_down_flag, write_busy;
  reg global_high_interrupt_enable, peripheral_low_interrupt_enable;
  reg [7:0] bank_select_register;
  reg [11:0] indirect_pointer_n [0:2];
  reg [20:0] stack_mem [0:STACK_DEPTH-1];
  reg [SP_WIDTH-1:0] sp;
  reg flush, second_pending, second_is_pointer, second_is_call;
  reg [7:0] first_low, pins_meta, pins_sync;
  wire [20:0] stack_top, ip_inc;
  wire take, room, empty;
  reg push;
  reg [20:0] push_value;
  reg [7:0] next_logic;
  // Two-flop synchroniser for the port pins.
  always @(posedge aclk) begin
    pins_meta <= port_b_pins;
    pins_sync <= pins_meta;
  end

  // RQ17 pin-sourced operand
  // A port operand in a read-modify-write comes from the pins.
  assign file_source = file_is_port ? pins_sync : file_latch_value;

  // A push lands in memory one edge late, so the top bypasses to the pending value.
  assign room = (sp != STACK_DEPTH[SP_WIDTH-1:0]);
  assign empty = (sp == {SP_WIDTH{1'b0}});
  assign stack_top = push ? push_value : empty ? 21'h00_0000 : stack_mem[sp - 1'b1];
  assign indirect_pointer_0 = indirect_pointer_n[0];
  assign indirect_pointer_1 = indirect_pointer_n[1];
  assign indirect_pointer_2 = indirect_pointer_n[2];

  // RQ5 idle second cycle
  // The flush cycle refuses the next word so it executes as an idle.
  assign instr_ready = control[`CTL_RUN] & ~flush;
  assign take = instr_valid & instr_ready;
  assign ip_inc = instruction_pointer + 21'h00_0002;

  // Evaluates a conditional jump test against the held flags.
  function cond_met;
    input [3:0] code;
    input [4:0] f;
    reg [3:0] tests;
    begin
      tests = {f[`ST_N], f[`ST_OV], f[`ST_C], f[`ST_Z]};
      cond_met = code[0] ^ tests[code[2:1]];
    end
  endfunction
  // Flag result of an 8-bit add of a and b plus carry in.
  function [4:0] add_flags;
    input [7:0] a;
    input [7:0] b;
    input cin;
    reg [8:0] sum;
    reg [4:0] low;
    begin
      sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      add_flags[`ST_C] = sum[8];
      add_flags[`ST_DC] = low[4];
      add_flags[`ST_Z] = (sum[7:0] == 8'h00);
      add_flags[`ST_OV] = (a[7] == b[7]) && (sum[7] != a[7]);
      add_flags[`ST_N] = sum[7];
    end
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite slave.
  // ----------------------------------------------------------------
  wire wr_fire, rd_fire, wr_hit;
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = s_axi_awready;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign wr_hit = (s_axi_awaddr == `OFS_CONTROL) || (s_axi_awaddr == `OFS_ACCUM);

  // Write response and read data, both one cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
      end
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `OFS_CONTROL: s_axi_rdata <= {29'h0, control};
          `OFS_STATUS: s_axi_rdata <= {{(16 - SP_WIDTH){1'b0}}, sp, 6'h00,
            write_busy, peripheral_low_interrupt_enable, global_high_interrupt_enable,
            power_down_flag, watchdog_expiry_flag, flags};
          `OFS_ACCUM: s_axi_rdata <= {24'h00_0000, working_accumulator};
          `OFS_IPTR: s_axi_rdata <= {11'h000, instruction_pointer};
          `OFS_BANK: s_axi_rdata <= {24'h00_0000, bank_select_register};
          `OFS_STACK: s_axi_rdata <= {11'h000, stack_top};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
    end
  end

  // Control register, written from the bus.
  always @(posedge aclk) begin
    if (!aresetn) begin
      control <= `CONTROL_RESET;
    end else if (wr_fire && s_axi_awaddr == `OFS_CONTROL && s_axi_wstrb[0]) begin
      control <= s_axi_wdata[2:0];
    end
  end

  // RQ18 prescaler clear
  // A timer-zero count write clears the prescaler only when assigned to it.
  always @(posedge aclk) begin
    prescaler_clear <= aresetn & timer_zero_write & control[`CTL_PRESCALE];
  end
  // Stack memory; push is raised only when a slot is free.
  always @(posedge aclk) begin
    if (push) stack_mem[sp - 1'b1] <= push_value;
  end
  // ----------------------------------------------------------------
  // Instruction execution.
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    flush <= 1'b0;
    push <= 1'b0;
    table_fetch <= 1'b0;
    table_store <= 1'b0;
    watchdog_kick <= 1'b0;
    standby <= 1'b0;
    soft_reset <= 1'b0;
    if (!aresetn) begin
      flags <= 5'h00;
      watchdog_expiry_flag <= 1'b1;
      power_down_flag <= 1'b1;
      global_high_interrupt_enable <= 1'b0;
      peripheral_low_interrupt_enable <= 1'b0;
      write_busy <= 1'b0;
      bank_select_register <= 8'h00;
      indirect_pointer_n[0] <= 12'h000;
      indirect_pointer_n[1] <= 12'h000;
      indirect_pointer_n[2] <= 12'h000;
      sp <= {SP_WIDTH{1'b0}};
      second_pending <= 1'b0;
      instruction_pointer <= 21'h00_0000;
      working_accumulator <= 8'h00;
      product <= 16'h0000;
      table_mode <= 2'b00;
    end else begin
      if (wr_fire && s_axi_awaddr == `OFS_ACCUM && s_axi_wstrb[0]) begin
        working_accumulator <= s_axi_wdata[7:0];
      end
      // RQ16 write runs on
      // A launched write stays busy until the memory terminates it; a new launch wins.
      if (write_done) write_busy <= 1'b0;
      if (take) begin
        instruction_pointer <= ip_inc;
        if (second_pending) begin
          second_pending <= 1'b0;
          // RQ4 lone second word
          // A 1111 word completes a two-word op only when one is pending.
          if (instr_word[15:12] == `NIB_SECOND) begin
            // RQ13 pointer literal
            if (second_is_pointer) begin
              if (first_low[5:4] != 2'b11) begin
                indirect_pointer_n[first_low[5:4]] <= {first_low[3:0], instr_word[7:0]};
              end
            end else begin
              // RQ3 absolute target
              instruction_pointer <= {instr_word[11:0], first_low, 1'b0};
              if (second_is_call) begin
                push <= room;
                push_value <= ip_inc;
                if (room) sp <= sp + 1'b1;
              end
            end
          end
        end else if (instr_word[15:12] == `NIB_RELJ) begin
          // RQ2 relative target
          instruction_pointer <= ip_inc + {{9{instr_word[10]}}, instr_word[10:0], 1'b0};
          flush <= 1'b1;
          if (instr_word[11]) begin
            push <= room;
            push_value <= ip_inc;
            if (room) sp <= sp + 1'b1;
          end
        end else if (instr_word[15:12] == `NIB_CONDJ) begin
          if (instr_word[11:8] <= `CONDJ_LAST) begin
            // RQ1 conditional test
            // RQ19 held flags
            if (cond_met(instr_word[11:8], flags)) begin
              instruction_pointer <= ip_inc + {{12{instr_word[7]}}, instr_word[7:0], 1'b0};
              flush <= 1'b1;
            end
          end else if (instr_word[11:9] == 3'b110 || instr_word[11:8] >= `LIT_POINTER) begin
            // RQ3 first word
            second_pending <= 1'b1;
            second_is_pointer <= (instr_word[11:8] == `LIT_POINTER);
            second_is_call <= (instr_word[11:9] == 3'b110);
            first_low <= instr_word[7:0];
          end
        end else if (instr_word[15:8] == `OP_SYSTEM) begin
          case (instr_word[7:0])
            // RQ6 standby and kick
            `SYS_STANDBY: begin
              standby <= 1'b1;
              watchdog_expiry_flag <= 1'b1;
              power_down_flag <= 1'b0;
            end
            `SYS_KICK: begin
              watchdog_kick <= 1'b1;
              watchdog_expiry_flag <= 1'b1;
              power_down_flag <= 1'b1;
            end
            // RQ7 stack-top moves
            `SYS_STORE_TOP: begin
              push <= room;
              push_value <= ip_inc;
              if (room) sp <= sp + 1'b1;
            end
            `SYS_REMOVE_TOP: if (!empty) sp <= sp - 1'b1;
            // RQ6 software reset
            `SYS_SOFT_RESET: begin
              soft_reset <= 1'b1;
              flags <= 5'h00;
              watchdog_expiry_flag <= 1'b1;
              power_down_flag <= 1'b1;
              global_high_interrupt_enable <= 1'b0;
              peripheral_low_interrupt_enable <= 1'b0;
              bank_select_register <= 8'h00;
              sp <= {SP_WIDTH{1'b0}};
              instruction_pointer <= 21'h00_0000;
            end
            default: begin
              // RQ8 returns
              if (instr_word[7:2] == 6'b000100) begin
                instruction_pointer <= stack_top;
                flush <= 1'b1;
                if (!empty) sp <= sp - 1'b1;
                if (!instr_word[1]) begin
                  global_high_interrupt_enable <= 1'b1;
                  peripheral_low_interrupt_enable <= 1'b1;
                end
              end else if (instr_word[7:3] == 5'b00001) begin
                // RQ14 table fetch
                // RQ15 table store
                flush <= 1'b1;
                table_mode <= instr_word[1:0];
                table_fetch <= ~instr_word[2];
                table_store <= instr_word[2];
                if (instr_word[2] && control[`CTL_WRITE_EN]) write_busy <= 1'b1;
              end
            end
          endcase
        end else if (instr_word[15:12] == `NIB_ZERO) begin
          case (instr_word[11:8])
            // RQ10 literal arithmetic
            `OP_ADD: begin
              working_accumulator <= working_accumulator + instr_word[7:0];
              flags <= add_flags(working_accumulator, instr_word[7:0], 1'b0);
            end
            `OP_SUB: begin
              working_accumulator <= instr_word[7:0] - working_accumulator;
              flags <= add_flags(instr_word[7:0], ~working_accumulator, 1'b1);
            end
            `OP_AND, `OP_IOR, `OP_XOR: begin
              working_accumulator <= next_logic;
              flags[`ST_Z] <= (next_logic == 8'h00);
              flags[`ST_N] <= next_logic[7];
            end
            // RQ9 literal return
            `OP_RETLIT: begin
              working_accumulator <= instr_word[7:0];
              instruction_pointer <= stack_top;
              flush <= 1'b1;
              if (!empty) sp <= sp - 1'b1;
            end
            // RQ11 move and multiply
            `OP_MOV: working_accumulator <= instr_word[7:0];
            `OP_MUL: product <= working_accumulator * instr_word[7:0];
            // RQ12 bank load
            default: begin
              if (instr_word[15:8] == `OP_BANK && instr_word[7:4] == `NIB_ZERO) begin
                bank_select_register <= {4'h0, instr_word[3:0]};
              end
            end
          endcase
        end
      end
    end
  end
  // Result of the three literal logic operations.
  always @* begin
    case (instr_word[9:8])
      2'b11: next_logic = working_accumulator & instr_word[7:0];
      2'b01: next_logic = working_accumulator | instr_word[7:0];
      default: next_logic = working_accumulator ^ instr_word[7:0];
    endcase
  end

endmodule
`default_nettype wire

// >>> tb/control_literal_table_decoder_sva.sv
// Checker for the control, literal and table instruction decoder.
`timescale 1ns/100ps
`default_nettype none
module decoder_checker (
  input wire aclk,
  input wire aresetn,
  input wire [15:0] instr_word,
  input wire instr_valid,
  input wire instr_ready,
  input wire file_is_port,
  input wire [7:0] file_latch_value,
  input wire [7:0] file_source,
  input wire table_fetch,
  input wire table_store,
  input wire [1:0] table_mode,
  input wire watchdog_kick,
  input wire standby,
  input wire [15:0] product,
  input wire [20:0] instruction_pointer,
  input wire [7:0] working_accumulator
);
  // ----------------------------------------------------------------
  // Accepted word and its sign-extended jump offsets.
  // ----------------------------------------------------------------
  wire take = instr_valid && instr_ready;
  wire [20:0] rel_off = {{9{instr_word[10]}}, instr_word[10:0], 1'b0};
  wire [20:0] cnd_off = {{12{instr_word[7]}}, instr_word[7:0], 1'b0};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Accepted relative and conditional jump words.
  sequence s_rel;
    take && instr_word[15:11] == 5'b11010;
  endsequence
  sequence s_cond;
    take && instr_word[15:11] == 5'b11100;
  endsequence
  property p_rel_ip;
    s_rel |=> instruction_pointer == $past(instruction_pointer) + 21'h0_0002 + $past(rel_off);
  endproperty
  a_rel_ip: assert property (p_rel_ip) else $error("Relative jump target wrong.");
  property p_rel_idle;
    s_rel |=> !instr_ready ##1 instr_ready;
  endproperty
  a_rel_idle: assert property (p_rel_idle) else $error("Jump idle cycle wrong.");
  property p_cond;
    s_cond |=> instruction_pointer == $past(instruction_pointer) + 21'h0_0002 || (!instr_ready
      && instruction_pointer == $past(instruction_pointer) + 21'h0_0002 + $past(cnd_off));
  endproperty
  a_cond: assert property (p_cond) else $error("Conditional jump result wrong.");
  property p_kick;
    take && instr_word == 16'h0004 |=> watchdog_kick && !standby;
  endproperty
  a_kick: assert property (p_kick) else $error("Watchdog kick pulse missing.");
  property p_standby;
    take && instr_word == 16'h0003 |=> standby && !watchdog_kick;
  endproperty
  a_standby: assert property (p_standby) else $error("Standby pulse missing.");
  property p_move;
    take && instr_word[15:8] == 8'h0E |=> working_accumulator == $past(instr_word[7:0]);
  endproperty
  a_move: assert property (p_move) else $error("Literal move wrong.");
  property p_mul;
    take && instr_word[15:8] == 8'h0D |=>
      product == $past(working_accumulator) * $past(instr_word[7:0]);
  endproperty
  a_mul: assert property (p_mul) else $error("Literal multiply wrong.");
  property p_fetch;
    take && instr_word[15:2] == 14'h0002 |=>
      table_fetch && !instr_ready && table_mode == $past(instr_word[1:0]);
  endproperty
  a_fetch: assert property (p_fetch) else $error("Table fetch decode wrong.");
  property p_store;
    take && instr_word[15:2] == 14'h0003 |=>
      table_store && !table_fetch && table_mode == $past(instr_word[1:0]);
  endproperty
  a_store: assert property (p_store) else $error("Table store decode wrong.");
  property p_latch_src;
    !file_is_port |-> file_source == file_latch_value;
  endproperty
  a_latch_src: assert property (p_latch_src) else $error("Latch source wrong.");
endmodule
bind control_literal_table_decoder decoder_checker chk_u (
  .aclk(aclk), .aresetn(aresetn), .instr_word(instr_word), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .file_is_port(file_is_port), .file_latch_value(file_latch_value),
  .file_source(file_source), .table_fetch(table_fetch), .table_store(table_store),
  .table_mode(table_mode), .watchdog_kick(watchdog_kick), .standby(standby),
  .product(product), .instruction_pointer(instruction_pointer),
  .working_accumulator(working_accumulator)
);
`default_nettype wire

// >>> tb/program_memory_model.sv
// Program memory model that hands queued instruction words to the decoder.
`timescale 1ns/100ps
`default_nettype none
module program_memory_model (
  input wire logic aclk,
  input wire logic instr_ready,
  input wire logic slow,
  output logic [15:0] instr_word,
  output logic instr_valid
);
  logic [15:0] words [$];
  // Offer the next word, hold it until taken, scramble the bus while idle.
  initial begin
    instr_word = 16'h0000;
    instr_valid = 1'b0;
    forever begin
      @(posedge aclk);
      if (!instr_valid || instr_ready) begin
        if (words.size() > 0 && !(slow && $urandom_range(1) == 0)) begin
          instr_valid <= 1'b1;
          instr_word <= words.pop_front();
        end else begin
          instr_valid <= 1'b0;
          instr_word <= ~instr_word;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_control_literal_table_decoder.sv
// Self-checking testbench for the control, literal and table instruction decoder.
`timescale 1ns/100ps
`default_nettype none
module test_control_literal_table_decoder;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, instr_valid, instr_ready;
  logic is_port, tzw, pclr, wdone, slow;
  logic [1:0] bresp, rresp;
  logic [7:0] awaddr, araddr, pins, latch, fsrc, a, k, r, x, n;
  logic [31:0] wdata, rdata, st;
  logic [15:0] instr_word;
  logic [11:0] fp1, p;
  logic [3:0] o, b;
  logic [8:0] s;
  logic [4:0] h;
  logic [10:0] m;
  logic [19:0] t;
  logic [20:0] ip;
  logic f;
  logic [33:0] exp_q [$];
  logic [3:0] ops [5] = '{4'hF, 4'h8, 4'hB, 4'h9, 4'hA};
  int fail_count = 0;
  int checked = 0;
  control_literal_table_decoder dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .instr_word(instr_word), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .port_b_pins(pins), .file_is_port(is_port), .file_latch_value(latch),
    .file_source(fsrc), .timer_zero_write(tzw), .prescaler_clear(pclr), .write_done(wdone),
    .table_fetch(), .table_store(), .table_mode(), .watchdog_kick(), .standby(),
    .soft_reset(), .product(), .instruction_pointer(), .working_accumulator(),
    .indirect_pointer_0(), .indirect_pointer_1(fp1), .indirect_pointer_2()
  );
  program_memory_model mem_u (.aclk(aclk), .instr_ready(instr_ready), .slow(slow),
    .instr_word(instr_word), .instr_valid(instr_valid));
  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic chk(input logic [33:0] seen, input logic [33:0] want);
    checked++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] e);
    exp_q.push_back({e, 32'h0000_0000});
    awaddr <= ad; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do @(posedge aclk); while (!awready);
    awvalid <= 1'b0; wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] e = 2'b00);
    exp_q.push_back({e, d});
    araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic op(input logic [15:0] w);
    mem_u.words.push_back(w);
  endtask
  task automatic drain;
    while (mem_u.words.size() != 0 || instr_valid) @(posedge aclk);
    repeat (3) @(posedge aclk);
  endtask
  // Clock at 40 MHz.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Compare each bus answer with the oldest expectation.
  always @(posedge aclk) begin
    if (bvalid && bready) chk({bresp, 32'h0000_0000}, exp_q.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
  end
  // Cut a hang short.
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    test_done;
  end
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, is_port, tzw, wdone, slow} = '0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; pins = 8'h00;
    void'($urandom(81295));
    latch = $urandom;
    st = 32'h0000_0060;
    ip = 21'h0_0000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, st);
    rd(8'h40, 32'h0000_0000, 2'b10);
    wr(8'h0C, 32'h0000_0001, 2'b10);
    wr(8'h00, 32'h0000_0001, 2'b00);
    foreach (ops[i]) begin
      a = $urandom; k = $urandom; o = ops[i];
      op({8'h0E, a}); op({8'h0D, k}); op({4'h0, o, k});
      ip = ip + 21'h0_0006;
      x = (o == 4'h8) ? ~a : a;
      s = {1'b0, k} + {1'b0, x} + {8'h00, o == 4'h8};
      h = {1'b0, k[3:0]} + {1'b0, x[3:0]} + {4'h0, o == 4'h8};
      r = (o == 4'hB) ? (a & k) : (o == 4'h9) ? (a | k) : (a ^ k);
      if (o == 4'hF || o == 4'h8) begin
        r = s[7:0];
        st[1:0] = {h[4], s[8]};
        st[3] = (k[7] == x[7]) && (r[7] != k[7]);
      end
      st[4] = r[7];
      st[2] = (r == 8'h00);
      drain;
      rd(8'h08, {24'h00_0000, r});
      rd(8'h04, st);
    end
    slow <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      n = $urandom;
      op({4'hE, c[3:0], n});
      f = (c < 2) ? st[2] : (c < 4) ? st[0] : (c < 6) ? st[3] : st[4];
      ip = ip + 21'h0_0002 + ((f ^ c[0]) ? {{12{n[7]}}, n, 1'b0} : 21'h0_0000);
    end
    m = $urandom;
    op({5'b11010, m});
    ip = ip + 21'h0_0002 + {{9{m[10]}}, m, 1'b0};
    drain;
    rd(8'h0C, {11'h000, ip});
    slow <= 1'b0;
    t = $urandom; k = $urandom; b = $urandom; p = $urandom;
    op({8'hEC, t[7:0]}); op({4'hF, t[19:8]}); op({8'h0C, k});
    t = $urandom;
    op({8'hEF, t[7:0]}); op({4'hF, t[19:8]}); op(16'hF123); op(16'h0000);
    op({12'h010, b}); op({12'hEE1, p[11:8]}); op({8'hF0, p[7:0]});
    ip = {t, 1'b0} + 21'h0_000A;
    drain;
    rd(8'h0C, {11'h000, ip});
    rd(8'h08, {24'h00_0000, k});
    rd(8'h10, {28'h000_0000, b});
    chk({22'h00_0000, fp1}, {22'h00_0000, p});
    op(16'h0010); op(16'h0003); op(16'h0005); op(16'h0006);
    st[8:6] = 3'b110;
    drain;
    rd(8'h04, st);
    rd(8'h0C, 32'h0000_0006);
    wr(8'h00, 32'h0000_0005, 2'b00);
    for (int i = 8; i < 16; i++) op({12'h000, i[3:0]});
    op(16'h0004);
    st[6] = 1'b1;
    st[9] = 1'b1;
    drain;
    rd(8'h04, st);
    wdone <= 1'b1;
    @(posedge aclk) wdone <= 1'b0;
    st[9] = 1'b0;
    rd(8'h04, st);
    op(16'h00FF);
    drain;
    rd(8'h0C, 32'h0000_0000);
    rd(8'h04, 32'h0000_0060);
    wr(8'h00, 32'h0000_0003, 2'b00);
    @(posedge aclk) tzw <= 1'b1;
    @(posedge aclk) tzw <= 1'b0;
    #1 chk({33'h0_0000_0000, pclr}, 34'h0_0000_0001);
    @(posedge aclk) is_port <= 1'b1;
    pins <= $urandom;
    repeat (3) @(posedge aclk);
    #1 chk({26'h000_0000, fsrc}, {26'h000_0000, pins});
    test_done;
  end
endmodule
`default_nettype wire
